// ---- rtl/lasd_pkg.sv ----
/*
  package for the logical address space decoder: region bounds, mode codes
  and sub-area placement constants.
  assumes: nothing beyond a systemverilog compiler.
*/
package lasd_pkg;
  // address width and region field position
  localparam int unsigned ADDR_W    = 32;
  localparam int unsigned REG_MSB   = 31;
  localparam int unsigned REG_LSB   = 30;

  // region bounds
  localparam logic [31:0] USER_LO   = 32'h0000_0000;
  localparam logic [31:0] USER_HI   = 32'h7fff_ffff;
  localparam logic [31:0] BOOT_LO   = 32'h8000_0000;
  localparam logic [31:0] BOOT_HI   = 32'hbfff_ffff;
  localparam logic [31:0] SYS_LO    = 32'hc000_0000;
  localparam logic [31:0] SYS_HI    = 32'hffff_ffff;

  // region codes from the top two address bits
  typedef enum logic [1:0] {
    RGN_USER0 = 2'h0,
    RGN_USER1 = 2'h1,
    RGN_BOOT  = 2'h2,
    RGN_SYS   = 2'h3
  } lasd_region_e;

  // operating modes as {mode_select_low, mode_select_high}
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_EXT    = 2'h1,
    MODE_PROC   = 2'h2,
    MODE_RSVD   = 2'h3
  } lasd_mode_e;

  // sub-area placement inside the user region (plain defaults)
  localparam logic [31:0] ROM_BASE    = 32'h0000_0000;
  localparam logic [31:0] ROM_SIZE    = 32'h0008_0000;
  localparam logic [31:0] PERI_BASE   = 32'h0080_0000;
  localparam logic [31:0] PERI_SIZE   = 32'h0000_4000;
  localparam logic [31:0] RAM_BASE    = 32'h0080_4000;
  localparam logic [31:0] RAM_SIZE    = 32'h0000_4000;
  localparam logic [31:0] EXT_BASE_SC = 32'h0010_0000;
  localparam logic [31:0] EXT_BASE_PR = 32'h0000_0000;
  localparam logic [31:0] EXT_SIZE    = 32'h0020_0000;
  localparam logic [31:0] ROM_BASE_EX = 32'h0000_0000;
endpackage

// ---- rtl/lasd_window.sv ----
/*
  window compare: flags an address that falls in [base, base+size).
  assumes: base+size does not wrap past the top of the address space.
*/
`timescale 1ns/10ps
`default_nettype none
module lasd_window (
  // compare inputs
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] base_i,
  input  wire logic [31:0] size_i,
  input  wire logic        en_i,
  // result
  output logic             hit_o
);
  logic [32:0] top;

  // upper bound kept one bit wider to avoid wrap
  assign top   = {1'b0, base_i} + {1'b0, size_i};
  assign hit_o = en_i && (addr_i >= base_i) && ({1'b0, addr_i} < top);
endmodule
`default_nettype wire

// ---- rtl/lasd_decoder.sv ----
/*
  logical address space decoder: registered region and sub-area selects for
  each address the cpu core presents, with mode-dependent placement of user
  rom and the external extended area.
  assumes: address, valid and mode pins are synchronous to CLOCK_I; mode pins
  are steady while addresses are issued.
*/
// Function
// - every address is handled as one full 32-bit linear quantity.
// - addresses 0000_0000 to 7fff_ffff select the 2-gbyte user region.
// - the user region offers rom, external, ram and peripheral selects.
// - user rom and external area placement follows the operating mode.
// - addresses 8000_0000 to bfff_ffff select the 1-gbyte boot region.
// - the boot region selects the on-board flash programming program.
// - addresses c000_0000 to ffff_ffff select the 1-gbyte system region.
// - three modes exist, chosen by the levels on the two mode pins.
// - mode pins 00 single-chip, 01 external, 10 processor, 11 reserved.
`timescale 1ns/10ps
`default_nettype none
module lasd_decoder (
  // clock and reset
  input  wire logic        CLOCK_I,
  input  wire logic        SYS_RST_I,
  // cpu address request
  input  wire logic [31:0] ADDR_I,
  input  wire logic        ADDR_VALID_I,
  // mode pins
  input  wire logic        MODE_SELECT_LOW_I,
  input  wire logic        MODE_SELECT_HIGH_I,
  // region selects
  output logic             SEL_USER_O,
  output logic             SEL_BOOT_O,
  output logic             SEL_SYS_O,
  // user sub-area selects
  output logic             SEL_ROM_O,
  output logic             SEL_EXT_O,
  output logic             SEL_RAM_O,
  output logic             SEL_PERI_O,
  output logic             SEL_NONE_O,
  // status
  output logic             MODE_RSVD_O,
  output logic [1:0]       MODE_O,
  output logic             SEL_VALID_O
);
  lasd_pkg::lasd_mode_e   mode;
  lasd_pkg::lasd_region_e region;
  logic        rom_en, ext_en;
  logic [31:0] rom_base, ext_base;
  logic        hit_rom, hit_ext, hit_ram, hit_peri;
  logic        user, boot, sys;
  logic        rom_d, ext_d, ram_d, peri_d, none_d;
  logic        user_d, boot_d, sys_d, vld_d, rsvd_d;
  logic [1:0]  mode_d;
  logic        rom_q, ext_q, ram_q, peri_q, none_q;
  logic        user_q, boot_q, sys_q, vld_q, rsvd_q;
  logic [1:0]  mode_q;

  // mode from pin pair, first pin is the high code bit
  assign mode = lasd_pkg::lasd_mode_e'({MODE_SELECT_LOW_I,
                                        MODE_SELECT_HIGH_I});

  // region from the top two bits of the full 32-bit address
  assign region = lasd_pkg::lasd_region_e'(
    ADDR_I[lasd_pkg::REG_MSB:lasd_pkg::REG_LSB]);

  // placement of rom and external area per mode
  always_comb begin
    rom_en   = 1'b0;
    ext_en   = 1'b0;
    rom_base = lasd_pkg::ROM_BASE;
    ext_base = lasd_pkg::EXT_BASE_SC;
    case (mode)
      lasd_pkg::MODE_SINGLE: begin
        rom_en = 1'b1;
      end
      lasd_pkg::MODE_EXT: begin
        rom_en   = 1'b1;
        ext_en   = 1'b1;
        rom_base = lasd_pkg::ROM_BASE_EX;
        ext_base = lasd_pkg::EXT_BASE_SC;
      end
      lasd_pkg::MODE_PROC: begin
        ext_en   = 1'b1;
        ext_base = lasd_pkg::EXT_BASE_PR;
      end
      default: begin
        rom_en = 1'b0;
        ext_en = 1'b0;
      end
    endcase
  end

  // sub-area windows inside the user region
  lasd_window u_rom (
    .addr_i (ADDR_I),
    .base_i (rom_base),
    .size_i (lasd_pkg::ROM_SIZE),
    .en_i   (rom_en),
    .hit_o  (hit_rom)
  );
  lasd_window u_ext (
    .addr_i (ADDR_I),
    .base_i (ext_base),
    .size_i (lasd_pkg::EXT_SIZE),
    .en_i   (ext_en),
    .hit_o  (hit_ext)
  );
  lasd_window u_ram (
    .addr_i (ADDR_I),
    .base_i (lasd_pkg::RAM_BASE),
    .size_i (lasd_pkg::RAM_SIZE),
    .en_i   (1'b1),
    .hit_o  (hit_ram)
  );
  lasd_window u_peri (
    .addr_i (ADDR_I),
    .base_i (lasd_pkg::PERI_BASE),
    .size_i (lasd_pkg::PERI_SIZE),
    .en_i   (1'b1),
    .hit_o  (hit_peri)
  );

  // one-hot region decode
  always_comb begin
    user = 1'b0;
    boot = 1'b0;
    sys  = 1'b0;
    case (region)
      lasd_pkg::RGN_USER0,
      lasd_pkg::RGN_USER1: user = 1'b1;
      lasd_pkg::RGN_BOOT:  boot = 1'b1;
      lasd_pkg::RGN_SYS:   sys  = 1'b1;
      default:             user = 1'b0;
    endcase
  end

  // next values: selects in priority ram, peripheral, rom, external
  always_comb begin
    vld_d  = ADDR_VALID_I;
    user_d = ADDR_VALID_I && user;
    boot_d = ADDR_VALID_I && boot;
    sys_d  = ADDR_VALID_I && sys;
    ram_d  = user_d && hit_ram;
    peri_d = user_d && !hit_ram && hit_peri;
    rom_d  = user_d && !hit_ram && !hit_peri && hit_rom;
    ext_d  = user_d && !hit_ram && !hit_peri && !hit_rom && hit_ext;
    none_d = user_d && !hit_ram && !hit_peri && !hit_rom && !hit_ext;
    rsvd_d = (mode == lasd_pkg::MODE_RSVD);
    mode_d = mode;
  end

  // output registers
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      vld_q  <= 1'b0;
      user_q <= 1'b0;
      boot_q <= 1'b0;
      sys_q  <= 1'b0;
      ram_q  <= 1'b0;
      peri_q <= 1'b0;
      rom_q  <= 1'b0;
      ext_q  <= 1'b0;
      none_q <= 1'b0;
      rsvd_q <= 1'b0;
      mode_q <= 2'h0;
    end else begin
      vld_q  <= vld_d;
      user_q <= user_d;
      boot_q <= boot_d;
      sys_q  <= sys_d;
      ram_q  <= ram_d;
      peri_q <= peri_d;
      rom_q  <= rom_d;
      ext_q  <= ext_d;
      none_q <= none_d;
      rsvd_q <= rsvd_d;
      mode_q <= mode_d;
    end
  end

  // drive ports
  assign SEL_VALID_O = vld_q;
  assign SEL_USER_O  = user_q;
  assign SEL_BOOT_O  = boot_q;
  assign SEL_SYS_O   = sys_q;
  assign SEL_RAM_O   = ram_q;
  assign SEL_PERI_O  = peri_q;
  assign SEL_ROM_O   = rom_q;
  assign SEL_EXT_O   = ext_q;
  assign SEL_NONE_O  = none_q;
  assign MODE_RSVD_O = rsvd_q;
  assign MODE_O      = mode_q;

  // checks
  one_region_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    vld_q |-> $onehot({user_q, boot_q, sys_q}))
    else $error("region selects not one-hot");
  user_range_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    ADDR_VALID_I && ADDR_I <= lasd_pkg::USER_HI |=> user_q)
    else $error("user address not in user region");
  boot_range_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    ADDR_VALID_I && ADDR_I >= lasd_pkg::BOOT_LO && ADDR_I <= lasd_pkg::BOOT_HI
    |=> boot_q)
    else $error("boot address not in boot region");
  sys_range_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    ADDR_VALID_I && ADDR_I >= lasd_pkg::SYS_LO |=> sys_q)
    else $error("system address not in system region");
  sub_onehot_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    user_q |-> $onehot({ram_q, peri_q, rom_q, ext_q, none_q}))
    else $error("user sub-area selects not one-hot");
  sub_in_user_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    (ram_q || peri_q || rom_q || ext_q) |-> user_q)
    else $error("sub-area select outside user region");
  proc_norom_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    mode_q == lasd_pkg::MODE_PROC |-> !rom_q)
    else $error("user rom selected in processor mode");
  single_noext_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    mode_q == lasd_pkg::MODE_SINGLE |-> !ext_q)
    else $error("external area selected in single-chip mode");
  idle_quiet_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    !ADDR_VALID_I |=> !(user_q || boot_q || sys_q))
    else $error("select raised without a valid address");
  rsvd_flag_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    MODE_SELECT_LOW_I && MODE_SELECT_HIGH_I |=> rsvd_q)
    else $error("reserved mode not flagged");

  // scenarios
  cov_boot_c: cover property (@(posedge CLOCK_I) boot_q);
  cov_sys_c:  cover property (@(posedge CLOCK_I) sys_q);
  cov_ext_c:  cover property (@(posedge CLOCK_I) ext_q);
  cov_peri_ram_c: cover property (@(posedge CLOCK_I) peri_q ##1 ram_q);
  cov_rsvd_c: cover property (@(posedge CLOCK_I) rsvd_q && none_q);
endmodule
`default_nettype wire

// ---- testbench/lasd_cpu_model.sv ----
/*
  cpu core model: issues logical addresses and holds the two mode pins.
  assumes: its tasks are called just after a rising clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module lasd_cpu_model (
  // debug tool access allowed
  input  wire logic        dbg_i,
  // address request and mode pins
  output logic      [31:0] addr_o,
  output logic             valid_o,
  output logic             mode_lo_o,
  output logic             mode_hi_o
);
  // idle pins at time zero
  initial begin
    addr_o = 32'h0;
    valid_o = 1'b0;
    mode_lo_o = 1'b0;
    mode_hi_o = 1'b0;
  end
  // present one address; a released bus shows the inverse, not the old value
  task automatic issue(input logic [31:0] a, input logic v);
    logic go;
    go = v && !(a[31:30] == 2'h3 && !dbg_i);
    valid_o = go;
    addr_o = go ? a : ~addr_o;
  endtask
  // code is {low pin, high pin}
  task automatic set_mode(input logic [1:0] m);
    mode_lo_o = m[1];
    mode_hi_o = m[0];
  endtask
endmodule
`default_nettype wire

// ---- testbench/lasd_decoder_tb.sv ----
/*
  self-checking bench for the address decoder, driving it from the cpu model.
  assumes: one 40 mhz clock, synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module lasd_decoder_tb;
  logic        clk;
  logic        rst;
  logic        dbg;
  logic [31:0] addr;
  logic        vld;
  logic        mlo;
  logic        mhi;
  logic        s_usr, s_boot, s_sys, s_rom, s_ext, s_ram, s_peri, s_none;
  logic        rsvd, s_vld;
  logic [1:0]  mode;
  wire  logic [11:0] got;
  int          err_total = 0;
  int          comparisons = 0;
  int          cycles = 0;
  assign got = {s_vld, s_usr, s_boot, s_sys, s_rom, s_ext, s_ram, s_peri,
                s_none, rsvd, mode};
  lasd_cpu_model lasd_cpu_model_i (
    .dbg_i(dbg), .addr_o(addr), .valid_o(vld),
    .mode_lo_o(mlo), .mode_hi_o(mhi));
  lasd_decoder lasd_decoder_i (
    .CLOCK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .ADDR_VALID_I(vld),
    .MODE_SELECT_LOW_I(mlo), .MODE_SELECT_HIGH_I(mhi),
    .SEL_USER_O(s_usr), .SEL_BOOT_O(s_boot), .SEL_SYS_O(s_sys),
    .SEL_ROM_O(s_rom), .SEL_EXT_O(s_ext), .SEL_RAM_O(s_ram),
    .SEL_PERI_O(s_peri), .SEL_NONE_O(s_none), .MODE_RSVD_O(rsvd),
    .MODE_O(mode), .SEL_VALID_O(s_vld));
  // expected selects worked out from the region and sub-area map
  function automatic logic [11:0] exp_f(logic [31:0] a, logic v,
                                        logic [1:0] m);
    logic u, rom, ext, ram, peri;
    u = v && !a[31];
    ram = u && a >= 32'h0080_4000 && a < 32'h0080_8000;
    peri = u && a >= 32'h0080_0000 && a < 32'h0080_4000;
    rom = u && !ram && !peri && m < 2'h2 && a < 32'h0008_0000;
    ext = u && !ram && !peri && !rom &&
          ((m == 2'h1 && a >= 32'h0010_0000 && a < 32'h0030_0000) ||
           (m == 2'h2 && a < 32'h0020_0000));
    return {v, u, v && a[31:30] == 2'h2, v && a[31:30] == 2'h3, rom, ext,
            ram, peri, u && !(rom | ext | ram | peri), m == 2'h3, m};
  endfunction
  // one request, answered one edge later
  task automatic step(input logic [31:0] a, input logic v,
                      input logic [1:0] m);
    lasd_cpu_model_i.issue(a, v);
    @(posedge clk);
    #1;
    `CHK(got, exp_f(a, v, m))
  endtask
  // region boundaries back to back, system space by the debug tool
  task automatic t_regions();
    logic [31:0] b [6];
    b = '{32'h0, 32'h7fff_ffff, 32'h8000_0000, 32'hbfff_ffff,
          32'hc000_0000, 32'hffff_ffff};
    dbg = 1'b1;
    foreach (b[i]) step(b[i], 1'b1, 2'h0);
    dbg = 1'b0;
    step(32'h0, 1'b0, 2'h0);
  endtask
  // sub-area edges in every mode code
  task automatic t_modes();
    logic [31:0] b [11];
    b = '{32'h0, 32'h7_ffff, 32'h8_0000, 32'h10_0000, 32'h2f_ffff,
          32'h30_0000, 32'h80_0000, 32'h80_3fff, 32'h80_4000, 32'h80_7fff,
          32'h80_8000};
    for (int m = 0; m < 4; m++) begin
      lasd_cpu_model_i.set_mode(2'(m));
      step(32'h0, 1'b0, 2'(m));
      foreach (b[i]) step(b[i], 1'b1, 2'(m));
    end
  endtask
  // reset in mid-run clears every output, even with a valid request pending
  task automatic t_reset();
    lasd_cpu_model_i.set_mode(2'h2);
    lasd_cpu_model_i.issue(32'h8000_0000, 1'b1);
    rst = 1'b1;
    @(posedge clk);
    #1;
    `CHK(got, 12'h0)
    rst = 1'b0;
    step(32'h8000_0000, 1'b1, 2'h2);
  endtask
  // verdict and end of run
  task automatic results();
    if (err_total == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // clock source
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total++;
      results();
    end
  end
  // main sequence
  initial begin
    rst = 1'b1;
    dbg = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    `CHK(got, 12'h0)
    rst = 1'b0;
    t_regions();
    t_modes();
    t_reset();
    results();
  end
endmodule
`default_nettype wire
